//--- vrc_pkg.sv
/*
  Package for the channel zero resource control block: register offsets,
  field positions, reset values and timing counts shared by all files except the bus front end.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
// How it works
// - Each map bit maps one class to channel
// - Map resets all ones; bit zero read-only
// - Writing one to bit 16 loads table
// - Table-load bit always reads back zero
// - Load matters only when scheme uses table
// - Channel identifier bits 26:24 read zero
// - Channel enable bit 31 reads one
// - Status set by entry write, cleared after load
// - Only fixed scheme advertised, capability bit zero
package vrc_pkg;
  // Register byte offsets.
  localparam logic [11:0] CAP_OFFSET = 12'h210;
  localparam logic [11:0] CTL_OFFSET = 12'h214;
  localparam logic [11:0] STS_OFFSET = 12'h218;
  localparam logic [11:0] TBL_OFFSET = 12'h240;
  // Control field positions.
  localparam int MAP_LSB = 0;
  localparam int MAP_W = 8;
  localparam int LOAD_BIT = 16;
  localparam int SEL_LSB = 17;
  localparam int SEL_W = 3;
  localparam int CHID_LSB = 24;
  localparam int CHID_W = 3;
  localparam int EN_BIT = 31;
  // Status field position.
  localparam int TSTS_BIT = 16;
  // Reset and fixed values.
  localparam logic [7:0] MAP_RESET = 8'hff;
  localparam logic [7:0] MAP_WRITABLE = 8'hfe;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [2:0] CHID_VALUE = 3'h0;
  localparam logic EN_VALUE = 1'b1;
  localparam logic [7:0] CAP_BITS = 8'h01;
  // Cycles the arbiter takes to latch a table after a load pulse.
  localparam int LOAD_CYCLES = 4;
endpackage

//--- vrc_load_seq.sv
/*
  Table load sequencer: turns a load pulse into a short latching busy
  period and keeps the table status flag. Assumes same-clock inputs.
*/
`timescale 1ns/1ps
module vrc_load_seq #(
  parameter int CYCLES = vrc_pkg::LOAD_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Events.
  input wire logic load_pulse_i,
  input wire logic entry_write_i,
  // State.
  output logic status_o,
  output logic done_o
);
  logic [3:0] count; // Remaining latch cycles.
  logic [3:0] next_count;
  logic next_status;
  logic next_done;

  // Computes the countdown and the status flag.
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    next_status = status_o;
    if (load_pulse_i) begin
      next_count = 4'(CYCLES);
    end else if (count != 4'h0) begin
      next_count = count - 4'h1;
      next_done = (count == 4'h1);
    end
    // A finished load clears; a new entry write sets and wins.
    if (next_done) begin
      next_status = 1'b0;
    end
    if (entry_write_i) begin
      next_status = 1'b1;
    end
  end

  // Registers the sequencer state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 4'h0;
      status_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      count <= next_count;
      status_o <= next_status;
      done_o <= next_done;
    end
  end

  // Status clears exactly at the end of the countdown.
  a_status_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    load_pulse_i && !entry_write_i ##1 !entry_write_i [*4]
    |=> done_o)
    else $error("load did not finish in time");
endmodule // vrc_load_seq

//--- vrc_wb_if.sv
/*
  Classic Wishbone slave front end: decodes one access per request and
  answers with a one-cycle ack. Assumes a same-clock master.
*/
`timescale 1ns/1ps
module vrc_wb_if (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus request.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  // Bus answer.
  output logic wb_ack_o,
  // Access strobes toward the register file.
  output logic wr_o,
  output logic rd_o
);
  logic next_ack; // Ack for the next cycle.

  // Acks a pending request once, then drops ack for a cycle.
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Registers the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= next_ack;
    end
  end

  // The write and read take effect in the acking cycle only.
  always_comb begin
    wr_o = next_ack && wb_we_i;
    rd_o = next_ack && !wb_we_i;
  end
endmodule // vrc_wb_if

//--- vrc_ctrl.sv
/*
  Channel zero resource control register bank with capability, status
  and arbitration table registers. Assumes classic Wishbone, 32-bit.
*/
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module vrc_ctrl #(
  parameter int TBL_WORDS = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Toward the port arbiter.
  output logic [7:0] class_channel_map_o,
  output logic [2:0] arb_scheme_select_o,
  output logic arb_table_load_o,
  output logic arb_table_status_o
);
  logic wr; // Write accepted this cycle.
  logic rd; // Read accepted this cycle.
  // The front end drives the bus ack straight from its own flip-flop, so
  // the ack and the registered read data appear in the same cycle.
  logic [7:0] map; // Class to channel map.
  logic [2:0] sel; // Scheme select.
  logic load; // One-cycle table load pulse.
  logic status; // Table status flag.
  logic [31:0] tbl [TBL_WORDS]; // Table entry words.
  logic [7:0] next_map;
  logic [2:0] next_sel;
  logic next_load;
  logic [31:0] next_dat;
  logic entry_wr; // Software writes a table entry.
  logic ctl_wr; // Software writes the control word.
  logic tbl_hit; // Address falls in the table.
  logic [11:0] tbl_rel; // Offset inside the table.

  vrc_wb_if u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_ack_o(wb_ack_o),
    .wr_o(wr),
    .rd_o(rd)
  );

  vrc_load_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_pulse_i(load),
    .entry_write_i(entry_wr),
    .status_o(status),
    .done_o()
  );

  // Decodes the address.
  always_comb begin
    tbl_rel = wb_adr_i - vrc_pkg::TBL_OFFSET;
    tbl_hit = (wb_adr_i >= vrc_pkg::TBL_OFFSET) &&
      (tbl_rel < 12'(TBL_WORDS * 4)) && (wb_adr_i[1:0] == 2'h0);
    ctl_wr = wr && (wb_adr_i == vrc_pkg::CTL_OFFSET);
    entry_wr = wr && tbl_hit && (wb_sel_i != 4'h0);
  end

  // Computes the next control state.
  always_comb begin
    next_map = map;
    next_sel = sel;
    next_load = 1'b0;
    if (ctl_wr && wb_sel_i[0]) begin
      // Bit zero keeps its reset value of one.
      next_map = (wb_dat_i[7:0] & vrc_pkg::MAP_WRITABLE) |
        (map & ~vrc_pkg::MAP_WRITABLE);
    end
    if (ctl_wr && wb_sel_i[2]) begin
      next_sel = wb_dat_i[vrc_pkg::SEL_LSB +: vrc_pkg::SEL_W];
      // The load bit is never stored; a one makes a pulse, zero does nothing.
      next_load = wb_dat_i[vrc_pkg::LOAD_BIT];
    end
  end

  // Computes read data; reserved bits read zero.
  always_comb begin
    next_dat = 32'h0;
    if (rd) begin
      unique case (1'b1)
        (wb_adr_i == vrc_pkg::CTL_OFFSET): begin
          next_dat[7:0] = map;
          next_dat[vrc_pkg::LOAD_BIT] = 1'b0;
          next_dat[vrc_pkg::SEL_LSB +: vrc_pkg::SEL_W] = sel;
          next_dat[vrc_pkg::CHID_LSB +: vrc_pkg::CHID_W] =
            vrc_pkg::CHID_VALUE;
          next_dat[vrc_pkg::EN_BIT] = vrc_pkg::EN_VALUE;
        end
        (wb_adr_i == vrc_pkg::CAP_OFFSET): begin
          next_dat[7:0] = vrc_pkg::CAP_BITS;
        end
        (wb_adr_i == vrc_pkg::STS_OFFSET): begin
          next_dat[vrc_pkg::TSTS_BIT] = status;
        end
        tbl_hit: begin
          next_dat = tbl[tbl_rel[4:2]];
        end
        default: begin
          next_dat = 32'h0;
        end
      endcase
    end
  end

  // Registers control state, read data and outputs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      map <= vrc_pkg::MAP_RESET;
      sel <= vrc_pkg::SEL_RESET;
      load <= 1'b0;
      wb_dat_o <= 32'h0;
      class_channel_map_o <= vrc_pkg::MAP_RESET;
      arb_scheme_select_o <= vrc_pkg::SEL_RESET;
      arb_table_load_o <= 1'b0;
      arb_table_status_o <= 1'b0;
    end else begin
      map <= next_map;
      sel <= next_sel;
      load <= next_load;
      wb_dat_o <= next_dat;
      class_channel_map_o <= next_map;
      arb_scheme_select_o <= next_sel;
      // The pulse is meaningful only for the arbiter, which uses the table
      // whenever the fixed scheme is selected.
      arb_table_load_o <= next_load;
      arb_table_status_o <= status;
    end
  end

  // Table storage with byte lanes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < TBL_WORDS; i++) begin
        tbl[i] <= 32'h0;
      end
    end else if (entry_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          tbl[tbl_rel[4:2]][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
        end
      end
    end
  end

  // The checks below watch the registered outputs and the strobes that
  // the front end derives from the bus. They are all on the core clock
  // and are switched off while the synchronous reset is held, because
  // every register then takes its reset value, whatever the strobes decode.

  // A software write of one to the table-load bit, with its byte lane.
  sequence s_load_write;
    ctl_wr && wb_sel_i[2] && wb_dat_i[vrc_pkg::LOAD_BIT];
  endsequence

  // The pulse toward the arbiter: high for one cycle, then low again.
  sequence s_load_pulse;
    arb_table_load_o ##1 !arb_table_load_o;
  endsequence

  // Map bit zero stays set: class zero can never leave channel zero.
  a_map_bit_zero: assert property (
    @(posedge clk_i) disable iff (rst_i) class_channel_map_o[0])
    else $error("map bit zero cleared");

  // A load write gives exactly one pulse in the cycle after it.
  a_load_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_load_write |=> s_load_pulse)
    else $error("load pulse wrong");

  // No pulse without a write of one; a stored bit would repeat it.
  a_load_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    arb_table_load_o |-> $past(ctl_wr) && $past(wb_dat_i[16]))
    else $error("spurious load pulse");

  // Control reads show fixed fields, a zero load bit and zero reserved
  // ranges, whatever software wrote there before.
  a_ctl_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && wb_adr_i == vrc_pkg::CTL_OFFSET |=> wb_dat_o[16] == 1'b0 &&
    wb_dat_o[31] && wb_dat_o[26:24] == 3'h0 && wb_dat_o[15:8] == 8'h0 &&
    wb_dat_o[23:20] == 4'h0 && wb_dat_o[30:27] == 4'h0)
    else $error("control read wrong");

  // Writes of map bits one to seven land in the map.
  a_map_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctl_wr && wb_sel_i[0] |=> class_channel_map_o[7:1] ==
    $past(wb_dat_i[7:1]))
    else $error("map write lost");

  // The map only moves on a control write with its byte lane.
  a_map_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(ctl_wr && wb_sel_i[0]) |=> $stable(class_channel_map_o))
    else $error("map changed without write");

  // A select write reaches the arbiter in the next cycle.
  a_sel_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctl_wr && wb_sel_i[2] |=> arb_scheme_select_o ==
    $past(wb_dat_i[19:17]))
    else $error("select write lost");

  // The select only moves on a control write with its byte lane.
  a_sel_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(ctl_wr && wb_sel_i[2]) |=> $stable(arb_scheme_select_o))
    else $error("select changed without write");

  // Capability reads advertise only bit zero.
  a_cap_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && wb_adr_i == vrc_pkg::CAP_OFFSET |=> wb_dat_o == 32'h1)
    else $error("capability wrong");

  // Status reads carry the flag in bit 16 and zero elsewhere.
  a_sts_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && wb_adr_i == vrc_pkg::STS_OFFSET |=>
    wb_dat_o[16] == arb_table_status_o && wb_dat_o[31:17] == 15'h0 &&
    wb_dat_o[15:0] == 16'h0)
    else $error("status read wrong");

  // Reads of unmapped addresses return zero but are still answered.
  a_unmapped_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd && !tbl_hit && wb_adr_i != vrc_pkg::CTL_OFFSET &&
    wb_adr_i != vrc_pkg::CAP_OFFSET && wb_adr_i != vrc_pkg::STS_OFFSET
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");

  // An entry write raises the status flag two cycles later.
  a_status_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    entry_wr |=> ##1 arb_table_status_o)
    else $error("status not set");

  // The flag only rises because of an entry write.
  a_status_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(arb_table_status_o) |-> $past(entry_wr, 2))
    else $error("status rose without write");

  // Every request is acked once within two cycles.
  a_ack_once: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o)
    else $error("no ack");

  // Ack lasts one cycle; a master that holds its request is acked again two cycles later.
  a_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // Ack only answers a request that stood in the cycle before.
  a_ack_cause: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
endmodule // vrc_ctrl

//--- tb.sv
/*
  Self-checking bench for the channel zero resource control bank.
  Assumes one clock, a synchronous reset and a classic Wishbone answer.
*/
`timescale 1ns/1ps
module tb;
  // One row: a request beside the readback and load pulse it should give.
  typedef struct packed {
    logic we;
    logic [11:0] a;
    logic [3:0] s;
    logic [31:0] d;
    logic [31:0] rd;
    logic ld;
  } vrc_row_t;
  // Clock, reset and bus signals driven by the bench.
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0000_0000;
  // Outputs of the design.
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic [7:0] map;
  logic [2:0] scheme;
  logic load;
  logic status;
  // Counters and scratch values.
  int fails = 0;
  int check_count = 0;
  logic [31:0] q;
  logic lq;
  vrc_row_t rows [8];
  // A 4 ns clock.
  always #2 clk_i = ~clk_i;
  vrc_ctrl i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .class_channel_map_o(map), .arb_scheme_select_o(scheme),
    .arb_table_load_o(load), .arb_table_status_o(status)
  );
  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; read data and the load pulse are taken at ack.
  task automatic wb(input logic w, input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r,
                    output logic l);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 50) begin
      fails++;
    end
    r = wb_dat_r;
    l = load;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    #40000;
    fails++;
    complete_run();
  end
  // Main sequence: reset values, table rows, then the hand-written cases.
  initial begin
    rows[0] = '{1'b1, vrc_pkg::CTL_OFFSET, 4'hf, 32'h0, 32'h8000_0001, 1'b0};
    rows[1] = '{1'b1, vrc_pkg::CTL_OFFSET, 4'hf, 32'hff00_ffaa,
                32'h8000_00ab, 1'b0};
    rows[2] = '{1'b1, vrc_pkg::CTL_OFFSET, 4'he, 32'h0001_0000,
                32'h8000_00ab, 1'b1};
    rows[3] = '{1'b1, vrc_pkg::CTL_OFFSET, 4'hb, 32'h0001_00ff,
                32'h8000_00ff, 1'b0};
    rows[4] = '{1'b0, vrc_pkg::CAP_OFFSET, 4'hf, 32'h0, 32'h1, 1'b0};
    rows[5] = '{1'b1, 12'h300, 4'hf, 32'hffff_ffff, 32'h0, 1'b0};
    rows[6] = '{1'b1, vrc_pkg::STS_OFFSET, 4'hf, 32'hffff_ffff, 32'h0, 1'b0};
    rows[7] = '{1'b1, vrc_pkg::CTL_OFFSET, 4'hf, 32'h0, 32'h8000_0001, 1'b0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Reset state of the ports and of the control word.
    chk({24'h0, map}, 32'hff);
    chk({29'h0, scheme}, 32'h0);
    chk({30'h0, load, status}, 32'h0);
    wb(1'b0, vrc_pkg::CTL_OFFSET, 4'hf, 32'h0, q, lq);
    chk(q, 32'h8000_00ff);
    // Each row writes (when asked), then reads the same address back.
    foreach (rows[i]) begin
      if (rows[i].we) begin
        wb(1'b1, rows[i].a, rows[i].s, rows[i].d, q, lq);
        chk({31'h0, lq}, {31'h0, rows[i].ld});
        chk({31'h0, load}, 32'h0);
      end
      wb(1'b0, rows[i].a, 4'hf, 32'h0, q, lq);
      chk(q, rows[i].rd);
      if (rows[i].a == vrc_pkg::CTL_OFFSET) begin
        chk({24'h0, map}, {24'h0, rows[i].rd[7:0]});
        chk({29'h0, scheme}, 32'h0);
      end
    end
    // A table entry write sets the status; it holds until a load ends.
    wb(1'b1, vrc_pkg::TBL_OFFSET, 4'hf, 32'h0000_3210, q, lq);
    repeat (12) @(posedge clk_i);
    chk({31'h0, status}, 32'h1);
    wb(1'b0, vrc_pkg::STS_OFFSET, 4'hf, 32'h0, q, lq);
    chk(q, 32'h0001_0000);
    wb(1'b1, vrc_pkg::CTL_OFFSET, 4'hf, 32'h0001_00ff, q, lq);
    chk({31'h0, lq}, 32'h1);
    chk({31'h0, load}, 32'h0);
    // Software polls the status until the arbiter has latched the table.
    for (int n = 0; n < 8; n++) begin
      wb(1'b0, vrc_pkg::STS_OFFSET, 4'hf, 32'h0, q, lq);
      if (q === 32'h0) begin
        break;
      end
    end
    chk(q, 32'h0);
    chk({31'h0, status}, 32'h0);
    // A second reset in mid-run restores a cleared map.
    wb(1'b1, vrc_pkg::CTL_OFFSET, 4'h1, 32'h0, q, lq);
    chk({24'h0, map}, 32'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({24'h0, map}, 32'hff);
    wb(1'b0, vrc_pkg::CTL_OFFSET, 4'hf, 32'h0, q, lq);
    chk(q, 32'h8000_00ff);
    complete_run();
  end
endmodule // tb
